// file: hdl/prb_bank.sv
// Functional notes
// - read/write fields read back software writes
// - hardware updates visible on next read
// - undefined-reset fields loaded before relied upon
// - writes to read-only fields are discarded
// - read-only reads return latest hardware value
// - defined read-only fields loaded at power-up
// - undefined read-only fields change only when specified
// - must-be-zero fields never set, read zero
// - unassigned selects are reserved
// - number 21 reserved, 22 implementation-owned
// - status at 12/0, cause at 13/0
// - exception pc 14/0, error pc 30/0
// - config at 16 selects 0 to 5
// - 28/29 even selects tag, odd data
// - kernel scratch 31/2-7, debug save 31/0
// - watch 18/19, perf 25, selects from zero
`timescale 1ns/10ps
module prb_bank (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        moveRd,
  input  wire logic        moveWr,
  input  wire logic [4:0]  moveRegNum,
  input  wire logic [2:0]  moveSel,
  input  wire logic [31:0] moveWrData,
  input  wire logic        excEvent,
  input  wire logic [31:0] excPc,
  input  wire logic [4:0]  excCode,
  input  wire logic        errEvent,
  input  wire logic [31:0] errPc,
  input  wire logic [1:0]  perfEvent,
  input  wire logic        cacheLoad,
  input  wire logic [31:0] cacheTagLowIn,
  input  wire logic [31:0] cacheDataLowIn,
  input  wire logic [31:0] cacheTagHighIn,
  input  wire logic [31:0] cacheDataHighIn,
  input  wire logic [31:0] configStrap,
  output logic             rdValid,
  output logic      [31:0] rdData,
  output logic      [31:0] statusWord,
  output logic      [31:0] causeWord,
  output logic      [31:0] exceptionReturnPc,
  output logic      [31:0] errorReturnPc
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0]                                 status;
    logic [31:0]                                 cause;
    logic [31:0]                                 excPc;
    logic [31:0]                                 errPc;
    logic [31:0]                                 config0;
    logic                                        strapDone;
    logic [1:0]                                  strapWait;
    logic [prb_pkg::WATCH_COUNT-1:0][31:0]       watchAddr;
    logic [prb_pkg::WATCH_COUNT-1:0][31:0]       watchCtl;
    logic [prb_pkg::PERF_COUNT-1:0][31:0]        perf;
    logic [31:0]                                 cache_tag_low;
    logic [31:0]                                 cache_data_low;
    logic [31:0]                                 cache_tag_high;
    logic [31:0]                                 cache_data_high;
    logic [31:0]                                 debugSave;
    logic [prb_pkg::SCRATCH_COUNT-1:0][31:0]     scratch;
    logic [31:0]                                 rdData;
    logic                                        rdValid;
  } prb_state_t;

  localparam prb_state_t STATE_RESET = '{status: prb_pkg::STATUS_RESET, default: '0};

  prb_state_t                st_reg;
  prb_state_t                st_next;
  logic [31:0]               strapSync;
  logic [31:0]               readValue;
  logic [2:0]                scrIdx;

  // ==========================================================
  // decode and strap synchroniser
  prb_move_if mv ();
  assign mv.regNum = moveRegNum;
  assign mv.sel    = moveSel;

  prb_decode u_decode (
    .mv (mv.decoder)
  );

  prb_sync u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pinIn   (configStrap),
    .syncOut (strapSync)
  );

  assign scrIdx = 3'(moveSel - prb_pkg::SEL_SCRATCH_FIRST);

  // ==========================================================
  // read multiplexer
  always_comb begin
    readValue = 32'h0000_0000;
    unique case (mv.slot)
      prb_pkg::SLOT_STATUS:  readValue = st_reg.status;
      prb_pkg::SLOT_CAUSE:   readValue = st_reg.cause;
      prb_pkg::SLOT_EXC_PC:  readValue = st_reg.excPc;
      prb_pkg::SLOT_CONFIG:  readValue = (moveSel == prb_pkg::SEL_ZERO) ?
                                         st_reg.config0 :
                                         prb_pkg::CONFIG_PRESET[moveSel];
      prb_pkg::SLOT_WADR:    readValue = st_reg.watchAddr[moveSel[0]];
      prb_pkg::SLOT_WCTL:    readValue = st_reg.watchCtl[moveSel[0]];
      prb_pkg::SLOT_PERF:    readValue = st_reg.perf[moveSel[1:0]];
      prb_pkg::SLOT_TAG_LO:  readValue = st_reg.cache_tag_low;
      prb_pkg::SLOT_DATA_LO: readValue = st_reg.cache_data_low;
      prb_pkg::SLOT_TAG_HI:  readValue = st_reg.cache_tag_high;
      prb_pkg::SLOT_DATA_HI: readValue = st_reg.cache_data_high;
      prb_pkg::SLOT_ERR_PC:  readValue = st_reg.errPc;
      prb_pkg::SLOT_DSAVE:   readValue = st_reg.debugSave;
      prb_pkg::SLOT_KSCR:    readValue = st_reg.scratch[scrIdx];
      prb_pkg::SLOT_NONE:    readValue = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // next state: software writes first, hardware updates override, counter increments add to the written value
  always_comb begin
    st_next = st_reg;
    st_next.rdValid = moveRd;
    st_next.rdData  = moveRd ? readValue : 32'h0000_0000;
    if (moveWr) begin
      unique case (mv.slot)
        // only writable bits are stored, so zero fields never take a one
        prb_pkg::SLOT_STATUS:  st_next.status = moveWrData & prb_pkg::STATUS_RW_MASK;
        prb_pkg::SLOT_CAUSE:   st_next.cause  = (st_reg.cause & ~prb_pkg::CAUSE_RW_MASK) |
                                                (moveWrData & prb_pkg::CAUSE_RW_MASK);
        prb_pkg::SLOT_EXC_PC:  st_next.excPc = moveWrData;
        prb_pkg::SLOT_CONFIG:  st_next.config0 = st_reg.config0;
        prb_pkg::SLOT_WADR:    st_next.watchAddr[moveSel[0]] = moveWrData;
        prb_pkg::SLOT_WCTL:    st_next.watchCtl[moveSel[0]] = moveWrData;
        prb_pkg::SLOT_PERF:    st_next.perf[moveSel[1:0]] = moveWrData;
        prb_pkg::SLOT_TAG_LO:  st_next.cache_tag_low = moveWrData;
        prb_pkg::SLOT_DATA_LO: st_next.cache_data_low = moveWrData;
        prb_pkg::SLOT_TAG_HI:  st_next.cache_tag_high = moveWrData;
        prb_pkg::SLOT_DATA_HI: st_next.cache_data_high = moveWrData;
        prb_pkg::SLOT_ERR_PC:  st_next.errPc = moveWrData;
        prb_pkg::SLOT_DSAVE:   st_next.debugSave = moveWrData;
        prb_pkg::SLOT_KSCR:    st_next.scratch[scrIdx] = moveWrData;
        prb_pkg::SLOT_NONE:    st_next.status = st_reg.status;
      endcase
    end
    // exception capture: code field moves only here
    if (excEvent) begin
      st_next.excPc = excPc;
      st_next.cause[prb_pkg::CAUSE_CODE_MSB:prb_pkg::CAUSE_CODE_LSB] = excCode;
    end
    if (errEvent) begin
      st_next.errPc = errPc;
    end
    if (cacheLoad) begin
      st_next.cache_tag_low  = cacheTagLowIn;
      st_next.cache_data_low = cacheDataLowIn;
      st_next.cache_tag_high  = cacheTagHighIn;
      st_next.cache_data_high = cacheDataHighIn;
    end
    // odd selects count events while the even select below enables them
    for (int i = 1; i < prb_pkg::PERF_COUNT; i += 2) begin
      if (perfEvent[i/2] && st_reg.perf[i-1][prb_pkg::PERF_ENABLE_BIT]) begin
        st_next.perf[i] = st_next.perf[i] + 32'h0000_0001;
      end
    end
    // straps settle through the synchroniser before capture
    if (!st_reg.strapDone) begin
      if (st_reg.strapWait == prb_pkg::STRAP_SETTLE) begin
        st_next.config0   = strapSync;
        st_next.strapDone = 1'b1;
      end else begin
        st_next.strapWait = 2'(st_reg.strapWait + 2'h1);
      end
    end
  end

  // fields with undefined reset are cleared here, so early reads are stable
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdValid           = st_reg.rdValid;
  assign rdData            = st_reg.rdData;
  assign statusWord        = st_reg.status;
  assign causeWord         = st_reg.cause;
  assign exceptionReturnPc = st_reg.excPc;
  assign errorReturnPc     = st_reg.errPc;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_rw_readback;
    (moveWr && moveRegNum == prb_pkg::REG_EXC_PC && moveSel == 3'h0 && !excEvent)
      |=> exceptionReturnPc == $past(moveWrData);
  endproperty
  a_rw_readback: assert property (p_rw_readback)
    else $error("exception pc did not take written value");

  property p_hw_update;
    errEvent |=> errorReturnPc == $past(errPc) ##1 (!$past(moveRd) || rdValid);
  endproperty
  a_hw_update: assert property (p_hw_update)
    else $error("error pc not captured on error event");

  property p_ro_discard;
    (moveWr && moveRegNum == prb_pkg::REG_CONFIG && st_reg.strapDone) |=> $stable(st_reg.config0);
  endproperty
  a_ro_discard: assert property (p_ro_discard)
    else $error("write changed a read-only config field");

  property p_ro_read;
    (moveRd && moveRegNum == prb_pkg::REG_CAUSE && moveSel == 3'h0)
      |=> rdValid && rdData == $past(causeWord);
  endproperty
  a_ro_read: assert property (p_ro_read)
    else $error("cause read does not match hardware value");

  property p_strap_load;
    $rose(st_reg.strapDone) |-> st_reg.config0 == $past(strapSync);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("config strap not captured");

  property p_code_cause;
    $changed(causeWord & prb_pkg::CAUSE_CODE_MASK) |-> $past(excEvent);
  endproperty
  a_code_cause: assert property (p_code_cause)
    else $error("cause code changed without an exception");

  property p_zero_fields;
    (statusWord & ~prb_pkg::STATUS_RW_MASK) == 32'h0000_0000;
  endproperty
  a_zero_fields: assert property (p_zero_fields)
    else $error("must-be-zero status bit is set");

  property p_reserved_read;
    (moveRd && (moveRegNum == prb_pkg::REG_RESV || moveRegNum == prb_pkg::REG_IMPL))
      |=> rdValid && rdData == 32'h0000_0000;
  endproperty
  a_reserved_read: assert property (p_reserved_read)
    else $error("reserved register read not zero");

  property p_reserved_write;
    (moveWr && moveRegNum == prb_pkg::REG_RESV && !excEvent && !errEvent)
      |=> $stable(statusWord) && $stable(exceptionReturnPc) && $stable(errorReturnPc);
  endproperty
  a_reserved_write: assert property (p_reserved_write)
    else $error("reserved write changed state");

  property p_tag_even;
    (moveWr && moveRegNum == prb_pkg::REG_CACHE_LOW && !moveSel[0] && !cacheLoad)
      |=> st_reg.cache_tag_low == $past(moveWrData);
  endproperty
  a_tag_even: assert property (p_tag_even)
    else $error("even select did not reach tag low");

  property p_scratch_map;
    (moveWr && moveRegNum == prb_pkg::REG_SCRATCH && moveSel == 3'h7)
      |=> st_reg.scratch[5] == $past(moveWrData);
  endproperty
  a_scratch_map: assert property (p_scratch_map)
    else $error("scratch select 7 not stored");

  property p_rd_pulse;
    rdValid == $past(moveRd);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read valid not one cycle after read request");

  property p_watch_rw;
    (moveWr && moveRegNum == prb_pkg::REG_WATCH_ADR && moveSel == 3'h1)
      |=> st_reg.watchAddr[1] == $past(moveWrData);
  endproperty
  a_watch_rw: assert property (p_watch_rw)
    else $error("watch address select 1 not stored");

  property p_perf_count;
    (perfEvent[0] && st_reg.perf[0][prb_pkg::PERF_ENABLE_BIT] &&
     !(moveWr && moveRegNum == prb_pkg::REG_PERF && moveSel == 3'h1))
      |=> st_reg.perf[1] == $past(st_reg.perf[1]) + 32'h0000_0001;
  endproperty
  a_perf_count: assert property (p_perf_count)
    else $error("enabled counter did not advance on event");

  property p_dsave_rw;
    (moveWr && moveRegNum == prb_pkg::REG_SCRATCH && moveSel == prb_pkg::SEL_ZERO)
      |=> st_reg.debugSave == $past(moveWrData);
  endproperty
  a_dsave_rw: assert property (p_dsave_rw)
    else $error("debug save select 0 not stored");

  property p_data_odd;
    (moveWr && moveRegNum == prb_pkg::REG_CACHE_HI && moveSel[0] && !cacheLoad)
      |=> st_reg.cache_data_high == $past(moveWrData);
  endproperty
  a_data_odd: assert property (p_data_odd)
    else $error("odd select did not reach data high");

  c_exception:  cover property (excEvent ##1 moveRd);
  c_strap_done: cover property ($rose(st_reg.strapDone));
  c_perf_count: cover property (perfEvent[0] && st_reg.perf[0][0]);
  c_resv_read:  cover property (moveRd && moveRegNum == prb_pkg::REG_RESV);
endmodule

// file: hdl/prb_pkg.sv
package prb_pkg;

  // ==========================================================
  // register numbers and selects
  localparam logic [4:0] REG_STATUS    = 5'h0C;
  localparam logic [4:0] REG_CAUSE     = 5'h0D;
  localparam logic [4:0] REG_EXC_PC    = 5'h0E;
  localparam logic [4:0] REG_CONFIG    = 5'h10;
  localparam logic [4:0] REG_WATCH_ADR = 5'h12;
  localparam logic [4:0] REG_WATCH_CTL = 5'h13;
  localparam logic [4:0] REG_RESV      = 5'h15;
  localparam logic [4:0] REG_IMPL      = 5'h16;
  localparam logic [4:0] REG_PERF      = 5'h19;
  localparam logic [4:0] REG_CACHE_LOW = 5'h1C;
  localparam logic [4:0] REG_CACHE_HI  = 5'h1D;
  localparam logic [4:0] REG_ERR_PC    = 5'h1E;
  localparam logic [4:0] REG_SCRATCH   = 5'h1F;
  localparam logic [2:0] SEL_ZERO      = 3'h0;
  localparam logic [2:0] SEL_CONFIG_LAST  = 3'h5;
  localparam logic [2:0] SEL_SCRATCH_FIRST = 3'h2;

  // ==========================================================
  // bank sizes
  localparam int WATCH_COUNT   = 2;
  localparam int PERF_COUNT    = 4;
  localparam int SCRATCH_COUNT = 6;
  localparam int CONFIG_COUNT  = 6;
  localparam int STRAP_WIDTH   = 32;

  // ==========================================================
  // field layouts and reset values
  localparam logic [31:0] STATUS_RW_MASK = 32'h0000_FF1F;
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0004;
  localparam logic [31:0] CAUSE_RW_MASK  = 32'h0000_0300;
  localparam int          CAUSE_CODE_LSB = 2;
  localparam int          CAUSE_CODE_MSB = 6;
  localparam logic [31:0] CAUSE_CODE_MASK = 32'h0000_007C;
  localparam int          PERF_ENABLE_BIT = 0;
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

  // presets for config selects 1..5; select 0 comes from straps
  localparam logic [CONFIG_COUNT-1:0][31:0] CONFIG_PRESET = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h8000_0000, 32'h0000_0000};

  // ==========================================================
  // decoded register classes
  typedef enum logic [3:0] {
    SLOT_NONE    = 4'h0,
    SLOT_STATUS  = 4'h1,
    SLOT_CAUSE   = 4'h2,
    SLOT_EXC_PC  = 4'h3,
    SLOT_CONFIG  = 4'h4,
    SLOT_WADR    = 4'h5,
    SLOT_WCTL    = 4'h6,
    SLOT_PERF    = 4'h7,
    SLOT_TAG_LO  = 4'h8,
    SLOT_DATA_LO = 4'h9,
    SLOT_TAG_HI  = 4'hA,
    SLOT_DATA_HI = 4'hB,
    SLOT_ERR_PC  = 4'hC,
    SLOT_DSAVE   = 4'hD,
    SLOT_KSCR    = 4'hE
  } prb_slot_t;

endpackage

// file: hdl/prb_move_if.sv
`timescale 1ns/10ps
interface prb_move_if;
  logic [4:0]         regNum;
  logic [2:0]         sel;
  prb_pkg::prb_slot_t slot;

  modport decoder (input regNum, input sel, output slot);
  modport bank    (output regNum, output sel, input slot);
endinterface

// file: hdl/prb_sync.sv
`timescale 1ns/10ps
module prb_sync (
  input  wire logic                               clk_sys,
  input  wire logic                               resetn,
  input  wire logic [prb_pkg::STRAP_WIDTH-1:0]    pinIn,
  output logic      [prb_pkg::STRAP_WIDTH-1:0]    syncOut
);
  // ==========================================================
  // two-stage synchroniser state
  typedef struct packed {
    logic [prb_pkg::STRAP_WIDTH-1:0] stage1;
    logic [prb_pkg::STRAP_WIDTH-1:0] stage2;
  } prb_sync_t;

  prb_sync_t st_reg;
  prb_sync_t st_next;

  always_comb begin
    st_next.stage1 = pinIn;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign syncOut = st_reg.stage2;
endmodule

// file: hdl/prb_decode.sv
`timescale 1ns/10ps
module prb_decode (
  prb_move_if.decoder mv
);
  // ==========================================================
  // register number and select to register class
  function automatic prb_pkg::prb_slot_t slotOf(input logic [4:0] num, input logic [2:0] sel);
    prb_pkg::prb_slot_t s;
    s = prb_pkg::SLOT_NONE;
    unique case (num)
      prb_pkg::REG_STATUS:    if (sel == prb_pkg::SEL_ZERO) s = prb_pkg::SLOT_STATUS;
      prb_pkg::REG_CAUSE:     if (sel == prb_pkg::SEL_ZERO) s = prb_pkg::SLOT_CAUSE;
      prb_pkg::REG_EXC_PC:    if (sel == prb_pkg::SEL_ZERO) s = prb_pkg::SLOT_EXC_PC;
      prb_pkg::REG_CONFIG:    if (sel <= prb_pkg::SEL_CONFIG_LAST) s = prb_pkg::SLOT_CONFIG;
      prb_pkg::REG_WATCH_ADR: if (32'(sel) < prb_pkg::WATCH_COUNT) s = prb_pkg::SLOT_WADR;
      prb_pkg::REG_WATCH_CTL: if (32'(sel) < prb_pkg::WATCH_COUNT) s = prb_pkg::SLOT_WCTL;
      prb_pkg::REG_PERF:      if (32'(sel) < prb_pkg::PERF_COUNT) s = prb_pkg::SLOT_PERF;
      prb_pkg::REG_CACHE_LOW: s = sel[0] ? prb_pkg::SLOT_DATA_LO : prb_pkg::SLOT_TAG_LO;
      prb_pkg::REG_CACHE_HI:  s = sel[0] ? prb_pkg::SLOT_DATA_HI : prb_pkg::SLOT_TAG_HI;
      prb_pkg::REG_ERR_PC:    if (sel == prb_pkg::SEL_ZERO) s = prb_pkg::SLOT_ERR_PC;
      prb_pkg::REG_SCRATCH: begin
        if (sel == prb_pkg::SEL_ZERO) s = prb_pkg::SLOT_DSAVE;
        else if (sel >= prb_pkg::SEL_SCRATCH_FIRST) s = prb_pkg::SLOT_KSCR;
      end
      // numbers 21, 22 and the rest hold nothing here
      default: s = prb_pkg::SLOT_NONE;
    endcase
    return s;
  endfunction

  assign mv.slot = slotOf(mv.regNum, mv.sel);
endmodule

// file: test/prb_core_model.sv
`timescale 1ns/10ps
module prb_core_model (
  input  wire logic        clk_sys,
  output logic             moveRd,
  output logic             moveWr,
  output logic      [4:0]  moveRegNum,
  output logic      [2:0]  moveSel,
  output logic      [31:0] moveWrData,
  input  wire logic        rdValid,
  input  wire logic [31:0] rdData
);
  // ==========================================================
  // idle state
  initial begin
    moveRd     = 1'b0;
    moveWr     = 1'b0;
    moveRegNum = 5'h00;
    moveSel    = 3'h0;
    moveWrData = 32'h0000_0000;
  end

  // released lines show the inverse of the last value, never a held copy
  task automatic idle();
    moveRd     = 1'b0;
    moveWr     = 1'b0;
    moveRegNum = ~moveRegNum;
    moveSel    = ~moveSel;
    moveWrData = ~moveWrData;
  endtask

  // ==========================================================
  // one-cycle register moves, launched on the falling edge
  // the caller chooses the data; must-be-zero bits get zero except in refusal cases
  task automatic wr(input logic [4:0] num, input logic [2:0] sel, input logic [31:0] data);
    @(negedge clk_sys);
    moveWr     = 1'b1;
    moveRegNum = num;
    moveSel    = sel;
    moveWrData = data;
    @(negedge clk_sys);
    idle();
  endtask

  task automatic rd(input logic [4:0] num, input logic [2:0] sel,
                    output logic [31:0] data, output logic valid);
    @(negedge clk_sys);
    moveRd     = 1'b1;
    moveRegNum = num;
    moveSel    = sel;
    @(negedge clk_sys);
    data  = rdData;
    valid = rdValid;
    idle();
  endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys;
  logic        resetn;
  logic        moveRd;
  logic        moveWr;
  logic [4:0]  moveRegNum;
  logic [2:0]  moveSel;
  logic [31:0] moveWrData;
  logic        excEvent;
  logic [31:0] excPc;
  logic [4:0]  excCode;
  logic        errEvent;
  logic [31:0] errPc;
  logic [1:0]  perfEvent;
  logic        cacheLoad;
  logic [31:0] cacheIn [4];
  logic [31:0] configStrap;
  logic        rdValid;
  logic [31:0] rdData;
  logic [31:0] statusWord;
  logic [31:0] causeWord;
  logic [31:0] exceptionReturnPc;
  logic [31:0] errorReturnPc;
  int          fail_count;
  int          comparisons;
  localparam logic [31:0] STRAP_VAL = 32'h5A3C_0F96;

  prb_bank prb_bank_inst (
    .clk_sys(clk_sys), .resetn(resetn), .moveRd(moveRd), .moveWr(moveWr),
    .moveRegNum(moveRegNum), .moveSel(moveSel), .moveWrData(moveWrData),
    .excEvent(excEvent), .excPc(excPc), .excCode(excCode), .errEvent(errEvent),
    .errPc(errPc), .perfEvent(perfEvent), .cacheLoad(cacheLoad),
    .cacheTagLowIn(cacheIn[0]), .cacheDataLowIn(cacheIn[1]), .cacheTagHighIn(cacheIn[2]),
    .cacheDataHighIn(cacheIn[3]), .configStrap(configStrap), .rdValid(rdValid),
    .rdData(rdData), .statusWord(statusWord), .causeWord(causeWord),
    .exceptionReturnPc(exceptionReturnPc), .errorReturnPc(errorReturnPc));

  prb_core_model prb_core_model_inst (
    .clk_sys(clk_sys), .moveRd(moveRd), .moveWr(moveWr), .moveRegNum(moveRegNum),
    .moveSel(moveSel), .moveWrData(moveWrData), .rdValid(rdValid), .rdData(rdData));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // verdict and comparisons
  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdChk(input logic [4:0] num, input logic [2:0] sel, input logic [31:0] exp);
    logic [31:0] d;
    logic        v;
    prb_core_model_inst.rd(num, sel, d, v);
    chk32({31'h0000_0000, v}, 32'h0000_0001, "read valid");
    chk32(d, exp, $sformatf("read %0d/%0d", num, sel));
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset();
    chk32(statusWord, 32'h0000_0004, "status after reset");
    chk32(causeWord, 32'h0000_0000, "cause after reset");
    rdChk(5'h0C, 3'h0, 32'h0000_0004);
    rdChk(5'h10, 3'h0, STRAP_VAL);
    rdChk(5'h10, 3'h1, 32'h8000_0000);
  endtask

  task automatic test_scratch();
    for (int s = 0; s < 8; s++) begin
      if (s != 1) prb_core_model_inst.wr(5'h1F, 3'(s), 32'hC0DE_0000 + s);
    end
    for (int s = 0; s < 8; s++) begin
      rdChk(5'h1F, 3'(s), (s == 1) ? 32'h0000_0000 : 32'hC0DE_0000 + s);
    end
  endtask

  task automatic test_watch();
    for (int s = 0; s < 2; s++) begin
      prb_core_model_inst.wr(5'h12, 3'(s), 32'hA000_0000 + s);
      prb_core_model_inst.wr(5'h13, 3'(s), 32'hB000_0000 + s);
    end
    for (int s = 0; s < 2; s++) begin
      rdChk(5'h12, 3'(s), 32'hA000_0000 + s);
      rdChk(5'h13, 3'(s), 32'hB000_0000 + s);
    end
  endtask

  task automatic test_status();
    prb_core_model_inst.wr(5'h0C, 3'h0, 32'hFFFF_FFFF);
    chk32(statusWord, 32'h0000_FF1F, "status masked");
    rdChk(5'h0C, 3'h0, 32'h0000_FF1F);
    prb_core_model_inst.wr(5'h0C, 3'h0, 32'h0000_0000);
    rdChk(5'h0C, 3'h0, 32'h0000_0000);
  endtask

  task automatic test_exception();
    prb_core_model_inst.wr(5'h0E, 3'h0, 32'h1357_9BDF);
    rdChk(5'h0E, 3'h0, 32'h1357_9BDF);
    prb_core_model_inst.wr(5'h0D, 3'h0, 32'hFFFF_FFFF);
    rdChk(5'h0D, 3'h0, 32'h0000_0300);
    @(negedge clk_sys);
    excEvent = 1'b1;
    excPc    = 32'h8000_0180;
    excCode  = 5'h15;
    @(negedge clk_sys);
    excEvent = 1'b0;
    excPc    = 32'h7FFF_FE7F;
    excCode  = 5'h0A;
    chk32(exceptionReturnPc, 32'h8000_0180, "exception pc");
    chk32(causeWord, 32'h0000_0354, "cause code");
    rdChk(5'h0E, 3'h0, 32'h8000_0180);
    rdChk(5'h0D, 3'h0, 32'h0000_0354);
    @(negedge clk_sys);
    errEvent = 1'b1;
    errPc    = 32'hBFC0_0000;
    @(negedge clk_sys);
    errEvent = 1'b0;
    errPc    = 32'h403F_FFFF;
    chk32(errorReturnPc, 32'hBFC0_0000, "error pc");
    rdChk(5'h1E, 3'h0, 32'hBFC0_0000);
  endtask

  task automatic test_reserved();
    logic [4:0] nums [6];
    logic [2:0] sels [6];
    nums = '{5'h10, 5'h10, 5'h0C, 5'h12, 5'h19, 5'h1E};
    sels = '{3'h6, 3'h7, 3'h1, 3'h2, 3'h4, 3'h1};
    for (int s = 0; s < 8; s++) begin
      prb_core_model_inst.wr(5'h15, 3'(s), 32'hFFFF_FFFF);
      rdChk(5'h15, 3'(s), 32'h0000_0000);
      prb_core_model_inst.wr(5'h16, 3'(s), 32'hFFFF_FFFF);
      rdChk(5'h16, 3'(s), 32'h0000_0000);
    end
    for (int i = 0; i < 6; i++) begin
      prb_core_model_inst.wr(nums[i], sels[i], 32'hFFFF_FFFF);
      rdChk(nums[i], sels[i], 32'h0000_0000);
    end
    prb_core_model_inst.wr(5'h10, 3'h1, 32'h0000_0000);
    rdChk(5'h10, 3'h1, 32'h8000_0000);
  endtask

  task automatic test_cache();
    @(negedge clk_sys);
    cacheIn   = '{32'h1111_2222, 32'h3333_4444, 32'h5555_6666, 32'h7777_8888};
    cacheLoad = 1'b1;
    @(negedge clk_sys);
    cacheLoad = 1'b0;
    cacheIn   = '{32'hEEEE_DDDD, 32'hCCCC_BBBB, 32'hAAAA_9999, 32'h8888_7777};
    rdChk(5'h1C, 3'h0, 32'h1111_2222);
    rdChk(5'h1C, 3'h7, 32'h3333_4444);
    rdChk(5'h1D, 3'h6, 32'h5555_6666);
    rdChk(5'h1D, 3'h1, 32'h7777_8888);
  endtask

  task automatic test_perf();
    prb_core_model_inst.wr(5'h19, 3'h0, 32'h0000_0001);
    prb_core_model_inst.wr(5'h19, 3'h1, 32'h0000_0000);
    @(negedge clk_sys);
    perfEvent = 2'h3;
    repeat (3) @(negedge clk_sys);
    perfEvent = 2'h0;
    rdChk(5'h19, 3'h1, 32'h0000_0003);
    rdChk(5'h19, 3'h3, 32'h0000_0000);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    fail_count  = 0;
    comparisons = 0;
    resetn      = 1'b0;
    excEvent    = 1'b0;
    excPc       = 32'h0000_0000;
    excCode     = 5'h00;
    errEvent    = 1'b0;
    errPc       = 32'h0000_0000;
    perfEvent   = 2'h0;
    cacheLoad   = 1'b0;
    cacheIn     = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    configStrap = STRAP_VAL;
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (10) @(negedge clk_sys);
    test_reset();
    test_scratch();
    test_watch();
    test_status();
    test_exception();
    test_reserved();
    test_cache();
    test_perf();
    finish_test();
  end

  initial begin
    #20000;
    fail_count++;
    $display("Error at %0t: run did not complete", $time);
    finish_test();
  end
endmodule
